// ### logic/mlc_pkg.sv
// shared constants, types and carriers of the manchester line codec
package mlc_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_PERIOD_NS = 100;
  localparam int BIT_CYCLES_DEF = BIT_PERIOD_NS / CLK_PERIOD_NS;
  // window as a fraction of a bit period, nominal three quarters
  localparam int WIN_NUM = 3;
  localparam int WIN_DEN = 4;
  localparam int WIN_CYCLES_DEF = (BIT_CYCLES_DEF * WIN_NUM) / WIN_DEN;
  // hunt timeout after a window, in bit periods
  localparam int LOCK_BITS = 1;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int CNT_W_DEF = 8;
  localparam int FIFO_DEPTH_DEF = 4;

  // ------------------------------------------------------------------
  // encodings and reset levels
  // ------------------------------------------------------------------
  localparam logic FORM_XOR_CLK = 1'b0;
  localparam logic FORM_DBL_FF = 1'b1;
  localparam logic LINE_RST = 1'b0;
  localparam logic BIT_RST = 1'b0;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SEND = 1'b1
  } mlc_tx_state_e;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_WIN = 2'b01,
    RX_WAIT = 2'b10
  } mlc_rx_state_e;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic data;
  } mlc_sym_s;

  typedef struct packed {
    logic data;
    logic synced;
  } mlc_rx_s;

endpackage

// ### logic/mlc_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module mlc_fifo
  import mlc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // flags come straight from the count, so full and empty are exact
  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage, no reset needed since reads are gated by the count
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers wrap at depth so non power of two depths work too
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else if (push && !pop)
    begin
      cnt_q <= cnt_q + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule

// ### logic/mlc_codec.sv
// manchester line codec: buffered encoder and window based receiver
//
// Functional notes
// - a zero bit is high for the first half, low for the second
// - a one bit is low for the first half, high for the second
// - every bit has a mid-bit transition used for resynchronizing
// - encoder form: data xor a bit clock of exactly half duty
// - encoder form: data xor a flip-flop toggling at twice bit rate
// - a final flip-flop retimes the encoder output against glitches
// - receiver makes a trigger pulse on every rising or falling change
// - each trigger starts a non-retriggerable window, about 3/4 bit
// - changes inside an active window are ignored
// - end of the window captures the recovered bit
// - sync is taken on the first change and kept while windows fit
// - link is meant for rates up to about ten megabits per second
// - window length comes from a programmable counter terminal value
`timescale 1ns/1ps
module mlc_codec
  import mlc_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF,
  parameter int CNT_W = CNT_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // transmit stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire mlc_sym_s tx_sym,
  input wire logic enc_form,
  output logic tx_busy,
  // line
  output logic line_out,
  input wire logic line_in,
  // receive stream and status
  input wire logic [CNT_W-1:0] win_len,
  output logic rx_valid,
  output mlc_rx_s rx_out,
  output logic rx_synced,
  output logic win_len_ok
);

  // ------------------------------------------------------------------
  // derived counts
  // ------------------------------------------------------------------
  // rate limit
  // bit rate is a parameter; at the default clock it gives ten mbit/s
  localparam logic [CNT_W-1:0] BIT_M1 = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(BIT_CYCLES / 2);
  localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(BIT_CYCLES / 2 - 1);
  localparam logic [CNT_W-1:0] FULL_CYC = CNT_W'(BIT_CYCLES);
  localparam logic [CNT_W-1:0] LOCK_M1 = CNT_W'(BIT_CYCLES * LOCK_BITS - 1);
  localparam logic [CNT_W-1:0] ONE_CYC = CNT_W'(1);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------------
  // transmit buffer
  // ------------------------------------------------------------------
  logic fifo_valid;
  logic fifo_ready;
  mlc_sym_s fifo_sym;

  // the encoder drains one symbol per bit period, so a burst fills it
  mlc_fifo #(
    .WIDTH($bits(mlc_sym_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_sym),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_sym)
  );

  // ------------------------------------------------------------------
  // encoder
  // ------------------------------------------------------------------
  mlc_tx_state_e tx_state_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic tx_data_q;
  logic dbl_q;
  logic line_q;
  logic bit_clk;
  logic enc_d;

  assign tx_busy = (tx_state_q == TX_SEND);
  // take the next symbol on the last cycle of a bit, so bits abut
  assign fifo_ready = !tx_busy || (tx_cnt_q == BIT_M1);
  // half duty bit clock, high in the first half of each bit
  assign bit_clk = (tx_cnt_q < HALF_CYC);

  // bit sequencing and symbol fetch
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_data_q <= BIT_RST;
    end
    else if (fifo_valid && fifo_ready)
    begin
      tx_state_q <= TX_SEND;
      tx_cnt_q <= '0;
      tx_data_q <= fifo_sym.data;
    end
    else if (tx_busy && (tx_cnt_q == BIT_M1))
    begin
      tx_state_q <= TX_IDLE; // underrun: line simply holds its level
      tx_cnt_q <= '0;
    end
    else if (tx_busy)
    begin
      tx_cnt_q <= tx_cnt_q + 1'b1;
    end
  end

  // double rate toggle
  // toggles at every half bit; forced high at bit start so it never
  // drifts out of phase after an idle gap
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dbl_q <= 1'b0;
    end
    else if (fifo_valid && fifo_ready)
    begin
      dbl_q <= 1'b1;
    end
    else if (tx_busy && ((tx_cnt_q == HALF_M1) || (tx_cnt_q == BIT_M1)))
    begin
      dbl_q <= !dbl_q;
    end
  end

  // form select
  // zero xor a high first half gives high then low; one gives the inverse
  always_comb
  begin
    enc_d = tx_data_q ^ ((enc_form == FORM_DBL_FF) ? dbl_q : bit_clk);
  end

  // output retiming
  // the xor may glitch when data and clock change together; only this
  // flip-flop reaches the pin, one cycle behind the counter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_q <= LINE_RST;
    end
    else if (tx_busy)
    begin
      line_q <= enc_d;
    end
  end

  assign line_out = line_q;

  property p_zero_shape;
    (tx_busy && tx_cnt_q == '0 && !tx_data_q) |=> line_q;
  endproperty
  a_zero_shape: assert property (p_zero_shape)
    else $error("zero bit does not open high");

  property p_zero_tail;
    (tx_busy && tx_cnt_q == HALF_CYC && !tx_data_q) |=> !line_q;
  endproperty
  a_zero_tail: assert property (p_zero_tail)
    else $error("zero bit does not close low");

  property p_one_shape;
    (tx_busy && tx_cnt_q == '0 && tx_data_q)
      |=> !line_q ##(BIT_CYCLES / 2) line_q;
  endproperty
  a_one_shape: assert property (p_one_shape)
    else $error("one bit is not low then high");

  property p_mid_edge;
    (tx_busy && tx_cnt_q == HALF_CYC) |=> (line_q != $past(line_q));
  endproperty
  a_mid_edge: assert property (p_mid_edge)
    else $error("no transition at mid-bit");

  property p_dbl_phase;
    tx_busy |-> (dbl_q == bit_clk);
  endproperty
  a_dbl_phase: assert property (p_dbl_phase)
    else $error("double rate flop out of phase");

  // ------------------------------------------------------------------
  // receiver front end
  // ------------------------------------------------------------------
  logic smp_q;
  logic dly_q;
  logic trig;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      smp_q <= LINE_RST;
      dly_q <= LINE_RST;
    end
    else
    begin
      smp_q <= line_in;
      dly_q <= smp_q;
    end
  end

  // trigger on either edge
  // the delayed copy plays the role of the inverter chain; one cycle wide
  assign trig = smp_q ^ dly_q;

  // ------------------------------------------------------------------
  // receiver window and capture
  // ------------------------------------------------------------------
  mlc_rx_state_e rx_state_q;
  logic [CNT_W-1:0] win_cnt_q;
  logic [CNT_W-1:0] win_load;
  logic win_end;
  logic win_start;
  logic synced_q;
  logic rx_valid_q;
  logic rx_data_q;
  logic mid_lvl_q;
  logic len_ok_q;

  // programmable terminal value
  // a zero length would never end; it is treated as one cycle
  always_comb
  begin
    win_load = (win_len == '0) ? '0 : win_len - ONE_CYC;
  end

  assign win_end = (rx_state_q == RX_WIN) && (win_cnt_q == '0);
  assign win_start = (rx_state_q != RX_WIN) && trig;

  // non-retriggerable window
  // in RX_WIN triggers are not looked at, so between-bit edges fall away
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_q <= RX_HUNT;
      win_cnt_q <= '0;
    end
    else
    begin
      case (rx_state_q)
        RX_HUNT:
        begin
          if (trig)
          begin
            rx_state_q <= RX_WIN;
            win_cnt_q <= win_load;
          end
        end
        RX_WIN:
        begin
          if (win_cnt_q == '0)
          begin
            rx_state_q <= RX_WAIT;
            win_cnt_q <= LOCK_M1;
          end
          else
          begin
            win_cnt_q <= win_cnt_q - 1'b1;
          end
        end
        RX_WAIT:
        begin
          if (trig)
          begin
            rx_state_q <= RX_WIN;
            win_cnt_q <= win_load;
          end
          else if (win_cnt_q == '0)
          begin
            rx_state_q <= RX_HUNT; // no mid-bit edge: stream has stopped
          end
          else
          begin
            win_cnt_q <= win_cnt_q - 1'b1;
          end
        end
        default:
        begin
          rx_state_q <= RX_HUNT;
        end
      endcase
    end
  end

  // synchronization flag
  // taken on the first change, dropped when a bit passes with no edge
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synced_q <= 1'b0;
    end
    else if (rx_state_q == RX_HUNT && trig)
    begin
      synced_q <= 1'b1;
    end
    else if (rx_state_q == RX_WAIT && !trig && win_cnt_q == '0)
    begin
      synced_q <= 1'b0;
    end
  end

  // level after the mid-bit edge
  // the window closes inside the next bit's first half, so the line no
  // longer shows this bit there; the level is held from the window start
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mid_lvl_q <= BIT_RST;
    end
    else if (win_start)
    begin
      mid_lvl_q <= smp_q;
    end
  end

  // capture at window end
  // the held mid-bit level is clocked out as the window closes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_valid_q <= 1'b0;
      rx_data_q <= BIT_RST;
    end
    else
    begin
      rx_valid_q <= win_end;
      if (win_end)
      begin
        rx_data_q <= mid_lvl_q;
      end
    end
  end

  // window length sanity, strictly between half and full bit
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      len_ok_q <= 1'b0;
    end
    else
    begin
      len_ok_q <= (win_len > HALF_CYC) && (win_len < FULL_CYC);
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_out = '{data: rx_data_q, synced: synced_q};
  assign rx_synced = synced_q;
  assign win_len_ok = len_ok_q;

  // every change opens a window when none is open
  sequence s_idle_trig;
    (rx_state_q != RX_WIN) && trig;
  endsequence
  property p_trig_opens;
    s_idle_trig |=> (rx_state_q == RX_WIN) && (win_cnt_q == $past(win_load));
  endproperty
  a_trig_opens: assert property (p_trig_opens)
    else $error("edge did not open a window");

  property p_no_retrig;
    (rx_state_q == RX_WIN && win_cnt_q != '0 && trig)
      |=> (rx_state_q == RX_WIN) && (win_cnt_q == $past(win_cnt_q) - 1'b1);
  endproperty
  a_no_retrig: assert property (p_no_retrig)
    else $error("window retriggered");

  sequence s_win_run;
    (rx_state_q == RX_WIN) [*6];
  endsequence
  property p_win_len;
    (s_idle_trig and (win_len == CNT_W'(6))) |=> s_win_run ##1 rx_valid_q;
  endproperty
  a_win_len: assert property (p_win_len)
    else $error("window length wrong");

  property p_capture;
    win_end |=> rx_valid_q && (rx_data_q == $past(mid_lvl_q));
  endproperty
  a_capture: assert property (p_capture)
    else $error("window end did not capture line level");

  // held level is the one just after the mid-bit edge
  property p_mid_lvl;
    win_start |=> (mid_lvl_q == $past(smp_q));
  endproperty
  a_mid_lvl: assert property (p_mid_lvl)
    else $error("mid-bit level not held");

  property p_sync_take;
    (rx_state_q == RX_HUNT && trig) |=> synced_q ##1 (rx_state_q == RX_WIN);
  endproperty
  a_sync_take: assert property (p_sync_take)
    else $error("sync not taken on first edge");

endmodule

// ### bench/mlc_far_end.sv
// far-end model: remote manchester transmitter and receiver on two wires
`timescale 1ns/1ps
module mlc_far_end
#(
  parameter int BIT_CYC = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // wire towards the codec
  input wire logic line_out,
  output logic line_in,
  // bits decoded from the codec's transmitter
  output logic far_valid,
  output logic far_bit,
  output logic [7:0] far_gap
);
  localparam int HALF = BIT_CYC / 2;
  localparam int WIN = (BIT_CYC * 3) / 4;
  logic seen_q;
  logic [7:0] win_q;
  logic [7:0] gap_q;

  // a live transmitter holds its last level between frames
  initial line_in = 1'b0;

  // send one bit
  // entered at a falling edge; halves are exactly half a bit each
  task automatic send_bit(input logic b);
    line_in = ~b;
    repeat (HALF) @(negedge sys_clk);
    line_in = b;
    repeat (HALF) @(negedge sys_clk);
  endtask

  // decode mid edges
  // the level right after an accepted edge is the bit; the window
  // hides the between-bit edge, gap reports spacing of mid edges
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seen_q <= 1'b0;
      win_q <= 8'h00;
      gap_q <= 8'hff;
      far_valid <= 1'b0;
      far_bit <= 1'b0;
      far_gap <= 8'h00;
    end
    else
    begin
      seen_q <= line_out;
      far_valid <= 1'b0;
      if (win_q == 8'h00 && line_out != seen_q)
      begin
        win_q <= 8'(WIN);
        far_valid <= 1'b1;
        far_bit <= line_out;
        far_gap <= gap_q;
        gap_q <= 8'h01;
      end
      else
      begin
        if (win_q != 8'h00)
          win_q <= win_q - 8'h01;
        if (gap_q != 8'hff)
          gap_q <= gap_q + 8'h01;
      end
    end
  end
endmodule

// ### bench/mlc_codec_test.sv
// self-checking testbench of the manchester line codec
`timescale 1ns/1ps
module mlc_codec_test
  import mlc_pkg::*;
;
  localparam int BITC = 8;
  localparam int LIMIT = 20000;
  logic sys_clk, rst_n, tx_valid, tx_ready, enc_form, tx_busy;
  logic line_out, line_in, rx_valid, rx_synced, win_len_ok;
  logic far_valid, far_bit, saw_full, tx_last, rx_last;
  logic [7:0] win_len, far_gap;
  logic [7:0] wl [6] = '{8'h06, 8'h05, 8'h07, 8'h06, 8'h06, 8'h06};
  mlc_sym_s tx_sym;
  mlc_rx_s rx_out;
  logic exp_tx [$];
  logic exp_rx [$];
  int seed, err_total, checked, cycles;

  mlc_codec #(.BIT_CYCLES(BITC), .CNT_W(8), .FIFO_DEPTH(4)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_sym(tx_sym), .enc_form(enc_form),
    .tx_busy(tx_busy), .line_out(line_out), .line_in(line_in),
    .win_len(win_len), .rx_valid(rx_valid), .rx_out(rx_out),
    .rx_synced(rx_synced), .win_len_ok(win_len_ok));

  mlc_far_end #(.BIT_CYC(BITC)) i_far (
    .sys_clk(sys_clk), .rst_n(rst_n), .line_out(line_out),
    .line_in(line_in), .far_valid(far_valid), .far_bit(far_bit),
    .far_gap(far_gap));

  // ------------------------------------------------------------------
  // clock, timeout and reporting
  // ------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hang counts as a mismatch and ends the run the normal way
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_total++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------------
  // hold the offer until ready is seen before the taking edge
  task automatic push(input logic b);
    tx_sym.data = b;
    enc_form = 1'($random(seed));
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1)
    begin
      saw_full = 1'b1;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    exp_tx.push_back(b);
    @(negedge sys_clk);
  endtask

  // first bit opposes the idle level so the first edge is a mid edge
  task automatic tx_burst(input int n);
    logic b;
    for (int i = 0; i < n; i++)
    begin
      b = (i == 0) ? ~tx_last : 1'($random(seed));
      push(b);
      tx_last = b;
    end
    tx_valid = 1'b0;
  endtask

  task automatic rx_burst(input int n);
    logic b;
    for (int i = 0; i < n; i++)
    begin
      b = (i == 0) ? ~rx_last : 1'($random(seed));
      exp_rx.push_back(b);
      i_far.send_bit(b);
      rx_last = b;
    end
  endtask

  // ------------------------------------------------------------------
  // output monitor: oldest note against each result
  // ------------------------------------------------------------------
  always @(negedge sys_clk)
  begin
    if (rst_n && rx_valid === 1'b1)
    begin
      if (exp_rx.size() == 0)
        check(16'h0001, 16'h0000);
      else
        check(16'(rx_out.data), 16'(exp_rx.pop_front()));
      check(16'(rx_synced), 16'h0001);
      check(16'(rx_out.synced), 16'h0001);
    end
    if (rst_n && far_valid === 1'b1)
    begin
      if (exp_tx.size() == 0)
        check(16'h0001, 16'h0000);
      else
        check(16'(far_bit), 16'(exp_tx.pop_front()));
      if (far_gap < 8'(2 * BITC))
        check(16'(far_gap), 16'(BITC));
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    seed = 14;
    err_total = 0;
    checked = 0;
    cycles = 0;
    saw_full = 1'b0;
    tx_last = 1'b0;
    rx_last = 1'b0;
    tx_valid = 1'b0;
    tx_sym = '0;
    enc_form = 1'b0;
    win_len = 8'h06;
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    for (int w = 3; w <= 9; w++)
    begin
      win_len = 8'(w);
      repeat (2) @(negedge sys_clk);
      check(16'(win_len_ok), 16'(w > 4 && w < 8));
    end
    $display("window range test done");
    // both directions at once, window length varied inside its range
    for (int r = 0; r < 6; r++)
    begin
      win_len = wl[r];
      fork
        tx_burst(7);
        rx_burst(6);
      join
      while (exp_tx.size() != 0 || exp_rx.size() != 0 || tx_busy !== 1'b0)
        @(negedge sys_clk);
      repeat (4 * BITC) @(negedge sys_clk);
      check(16'(rx_synced), 16'h0000);
      check(16'(tx_ready), 16'h0001);
      $display("traffic round %0d done", r);
    end
    // the bursts outrun the encoder, so the buffer must have refused
    check(16'(saw_full), 16'h0001);
    $display("buffer fill test done");
    complete_run();
  end
endmodule
